// ### src/csm_pkg.sv
package csm_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CLOCK_SOURCE_SELECT = 8'ha9;
  localparam logic [7:0] IDX_EXTERNAL_OSC_CONTROL = 8'hb1;
  localparam logic [7:0] IDX_CLOCK_MULT_CONTROL = 8'hb9;

  // Reset values
  localparam logic [7:0] RST_CLOCK_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_EXTERNAL_OSC_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_MULT_CONTROL = 8'h00;

  // Field positions
  localparam int unsigned XO_VALID_BIT = 7;
  localparam int unsigned XO_MODE_LSB = 4;
  localparam int unsigned XO_FREQ_LSB = 0;
  localparam int unsigned CM_EN_BIT = 7;
  localparam int unsigned CM_INIT_BIT = 6;
  localparam int unsigned CM_RDY_BIT = 5;
  localparam int unsigned CM_SEL_LSB = 0;
  localparam int unsigned CS_USB_LSB = 4;
  localparam int unsigned CS_SYS_LSB = 0;

  // External oscillator modes
  localparam logic [2:0] XM_CMOS = 3'h2;
  localparam logic [2:0] XM_CMOS_DIV2 = 3'h3;
  localparam logic [2:0] XM_RC = 3'h4;
  localparam logic [2:0] XM_CAP = 3'h5;
  localparam logic [2:0] XM_XTAL = 3'h6;
  localparam logic [2:0] XM_XTAL_DIV2 = 3'h7;
  localparam logic [2:0] XF_XTAL_MAX = 3'h7;

  // Multiplier source codes
  localparam logic [1:0] MS_INT = 2'h0;
  localparam logic [1:0] MS_EXT = 2'h1;
  localparam logic [1:0] MS_EXT_DIV2 = 2'h2;
  localparam logic [1:0] MS_RSVD = 2'h3;

  // System clock codes
  localparam logic [2:0] SC_INT = 3'h0;
  localparam logic [2:0] SC_EXT = 3'h1;
  localparam logic [2:0] SC_MULT_DIV2 = 3'h2;
  localparam logic [2:0] SC_MULT = 3'h3;
  localparam logic [2:0] SC_LFO = 3'h4;

  // USB clock codes
  localparam logic [2:0] UC_MULT = 3'h0;
  localparam logic [2:0] UC_INT_DIV2 = 3'h1;
  localparam logic [2:0] UC_EXT = 3'h2;
  localparam logic [2:0] UC_EXT_DIV2 = 3'h3;
  localparam logic [2:0] UC_EXT_DIV3 = 3'h4;
  localparam logic [2:0] UC_EXT_DIV4 = 3'h5;

  localparam int unsigned MULT_FACTOR = 4;

  // Timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MULT_LOCK_NS = 2000;
  localparam int unsigned XTAL_SETTLE_NS = 500;
  localparam int unsigned MULT_LOCK_CYC = (MULT_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned XTAL_SETTLE_CYC = (XTAL_SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    CSM_M_OFF = 4'b0001,
    CSM_M_ENABLED = 4'b0010,
    CSM_M_LOCKING = 4'b0100,
    CSM_M_LOCKED = 4'b1000
  } csm_mult_state_e;

endpackage : csm_pkg

// ### src/csm_settle_timer.sv
module csm_settle_timer #(
  parameter int unsigned CYCLES = 16
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic run, // Count while high, restart when low
  output logic done // High once run held for CYCLES
);

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] count;

  initial
  begin
    if (CYCLES < 1)
    begin
      $error("csm_settle_timer: CYCLES must be at least one");
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
    end
    else if (!run)
    begin
      count <= '0;
    end
    else if (count != LAST)
    begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done <= 1'b0;
    end
    else
    begin
      done <= run && (count == LAST);
    end
  end

endmodule : csm_settle_timer

// ### src/csm_clock_ctrl.sv
// Summary of operation
// - Crystal valid flag reads one once the crystal has settled, crystal modes only.
// - Frequency control field is 3 bits; code 111 means crystal above 10 MHz.
// - Multiplier takes a 12 MHz input times four for 48 MHz USB.
// - Ready bit 5 reports lock; software polls it before using the output.
// - Multiplier source: 00 internal, 01 external, 10 external halved, 11 reserved.
// - System clock: internal, external, multiplier/2, multiplier, low-frequency; rest reserved.
// - Undivided multiplier system clock exists only on 48 MHz rated variants.
// - Internal oscillator is usable at once, no settling wait.
// - External oscillator stays running whatever the system clock choice.
// - USB clock: multiplier, internal/2, external /1 /2 /3 /4; 110, 111 reserved.
// - Clock select bits 7 and 3 read zero and ignore writes.
module csm_clock_ctrl #(
  parameter bit RATED_48MHZ = 1'b1,
  parameter int unsigned MULT_LOCK_CYCLES = csm_pkg::MULT_LOCK_CYC,
  parameter int unsigned XTAL_SETTLE_CYCLES = csm_pkg::XTAL_SETTLE_CYC
) (
  input wire logic pclk, // APB clock
  input wire logic presetn, // APB reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [csm_pkg::ADDR_W-1:0] paddr, // APB byte address
  input wire logic [csm_pkg::DATA_W-1:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [csm_pkg::DATA_W-1:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ext_amp_ok, // Crystal amplitude detector settled
  output logic ext_osc_enable, // External oscillator circuit on
  output logic [2:0] ext_osc_mode_field, // External oscillator mode
  output logic [2:0] ext_osc_freq_ctrl, // External oscillator drive range
  output logic ext_osc_div2, // External oscillator output halved
  output logic ext_osc_xtal_pins, // Both crystal pins claimed
  output logic mult_enable_bit, // Multiplier powered
  output logic mult_init_bit, // Multiplier initialise request
  output logic mult_ready_bit, // Multiplier locked
  output logic [1:0] mult_source_field, // Multiplier input selection
  output logic mult_run, // Multiplier output may be used
  output logic [4:0] sysclk_onehot, // Int, ext, mult/2, mult, low-freq
  output logic [2:0] usb_onehot, // Multiplier, internal/2, external
  output logic [1:0] usb_ext_div // External divide minus one
);

  initial
  begin
    if (MULT_LOCK_CYCLES < 1 || XTAL_SETTLE_CYCLES < 1)
    begin
      $error("csm_clock_ctrl: settle counts must be at least one");
    end
  end

  logic [2:0] xo_mode, xo_freq;
  logic cm_en, cm_init;
  logic [1:0] cm_sel;
  logic [2:0] cs_usb, cs_sys;
  logic xtal_valid, xtal_mode, xtal_settled, lock_done;
  csm_pkg::csm_mult_state_e mstate, next_mstate;

  // Bus decode
  logic access, wr_fire, word_ok, hit_cs, hit_xo, hit_cm, mapped;
  logic [7:0] wbyte, rbyte;

  assign access = psel && penable;
  assign wr_fire = access && pready && pwrite && pstrb[0] && mapped;
  assign word_ok = (paddr[csm_pkg::ADDR_W-1:10] == '0) && (paddr[1:0] == 2'h0);
  assign hit_cs = word_ok && (paddr[9:2] == csm_pkg::IDX_CLOCK_SOURCE_SELECT);
  assign hit_xo = word_ok && (paddr[9:2] == csm_pkg::IDX_EXTERNAL_OSC_CONTROL);
  assign hit_cm = word_ok && (paddr[9:2] == csm_pkg::IDX_CLOCK_MULT_CONTROL);
  assign mapped = hit_cs || hit_xo || hit_cm;
  assign wbyte = pwdata[7:0];

  always_comb
  begin
    rbyte = 8'h00;
    if (hit_cs)
    begin
      // Bits 7 and 3 stay zero
      rbyte[csm_pkg::CS_USB_LSB +: 3] = cs_usb;
      rbyte[csm_pkg::CS_SYS_LSB +: 3] = cs_sys;
    end
    else if (hit_xo)
    begin
      rbyte[csm_pkg::XO_VALID_BIT] = xtal_valid;
      rbyte[csm_pkg::XO_MODE_LSB +: 3] = xo_mode;
      rbyte[csm_pkg::XO_FREQ_LSB +: 3] = xo_freq;
    end
    else if (hit_cm)
    begin
      rbyte[csm_pkg::CM_EN_BIT] = cm_en;
      rbyte[csm_pkg::CM_INIT_BIT] = cm_init;
      rbyte[csm_pkg::CM_RDY_BIT] = mult_ready_bit;
      rbyte[csm_pkg::CM_SEL_LSB +: 2] = cm_sel;
    end
  end

  // One wait state so that read data leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else
    begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      if (access && !pready && !pwrite)
      begin
        prdata <= {{(csm_pkg::DATA_W - 8){1'b0}}, rbyte};
      end
    end
  end

  // External oscillator control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xo_mode <= csm_pkg::RST_EXTERNAL_OSC_CONTROL[csm_pkg::XO_MODE_LSB +: 3];
      xo_freq <= csm_pkg::RST_EXTERNAL_OSC_CONTROL[csm_pkg::XO_FREQ_LSB +: 3];
    end
    else if (wr_fire && hit_xo)
    begin
      xo_mode <= wbyte[csm_pkg::XO_MODE_LSB +: 3];
      xo_freq <= wbyte[csm_pkg::XO_FREQ_LSB +: 3];
    end
  end

  assign xtal_mode = (xo_mode == csm_pkg::XM_XTAL) || (xo_mode == csm_pkg::XM_XTAL_DIV2);

  // Amplitude detector must hold steady before the flag rises
  csm_settle_timer #(
    .CYCLES(XTAL_SETTLE_CYCLES)
  ) u_xtal_settle (
    .pclk(pclk),
    .presetn(presetn),
    .run(xtal_mode && ext_amp_ok),
    .done(xtal_settled)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xtal_valid <= 1'b0;
    end
    else
    begin
      xtal_valid <= xtal_mode && xtal_settled;
    end
  end

  // Pin outputs follow only the mode and frequency fields, not the system clock choice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_osc_enable <= 1'b0;
      ext_osc_mode_field <= 3'h0;
      ext_osc_freq_ctrl <= 3'h0;
      ext_osc_div2 <= 1'b0;
      ext_osc_xtal_pins <= 1'b0;
    end
    else
    begin
      ext_osc_enable <= xo_mode[2] || xo_mode[1];
      ext_osc_mode_field <= xo_mode;
      ext_osc_freq_ctrl <= xo_freq;
      ext_osc_div2 <= (xo_mode == csm_pkg::XM_CMOS_DIV2)
        || (xo_mode == csm_pkg::XM_XTAL_DIV2);
      ext_osc_xtal_pins <= xtal_mode;
    end
  end

  // Multiplier control; zero write drops enable and init together
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cm_en <= csm_pkg::RST_CLOCK_MULT_CONTROL[csm_pkg::CM_EN_BIT];
      cm_init <= csm_pkg::RST_CLOCK_MULT_CONTROL[csm_pkg::CM_INIT_BIT];
      cm_sel <= csm_pkg::RST_CLOCK_MULT_CONTROL[csm_pkg::CM_SEL_LSB +: 2];
    end
    else if (wr_fire && hit_cm)
    begin
      cm_en <= wbyte[csm_pkg::CM_EN_BIT];
      // Init only accepted alongside enable
      cm_init <= wbyte[csm_pkg::CM_INIT_BIT] && wbyte[csm_pkg::CM_EN_BIT];
      if (wbyte[csm_pkg::CM_SEL_LSB +: 2] != csm_pkg::MS_RSVD)
      begin
        cm_sel <= wbyte[csm_pkg::CM_SEL_LSB +: 2];
      end
    end
  end

  logic init_req;

  assign init_req = wr_fire && hit_cm && wbyte[csm_pkg::CM_EN_BIT]
    && wbyte[csm_pkg::CM_INIT_BIT];

  always_comb
  begin
    next_mstate = mstate;
    unique case (mstate)
      csm_pkg::CSM_M_OFF: next_mstate = csm_pkg::CSM_M_ENABLED;
      csm_pkg::CSM_M_ENABLED:
      begin
        if (cm_init)
        begin
          next_mstate = csm_pkg::CSM_M_LOCKING;
        end
      end
      csm_pkg::CSM_M_LOCKING:
      begin
        if (lock_done)
        begin
          next_mstate = csm_pkg::CSM_M_LOCKED;
        end
      end
      csm_pkg::CSM_M_LOCKED:
      begin
        if (init_req)
        begin
          next_mstate = csm_pkg::CSM_M_LOCKING;
        end
      end
      default: next_mstate = csm_pkg::CSM_M_OFF;
    endcase
    // Disable wins over every state, so ready can never outlive enable
    if (!cm_en)
    begin
      next_mstate = csm_pkg::CSM_M_OFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mstate <= csm_pkg::CSM_M_OFF;
    end
    else
    begin
      mstate <= next_mstate;
    end
  end

  // Stands in for the analog lock detector
  csm_settle_timer #(
    .CYCLES(MULT_LOCK_CYCLES)
  ) u_mult_lock (
    .pclk(pclk),
    .presetn(presetn),
    .run((mstate == csm_pkg::CSM_M_LOCKING) && cm_en && !init_req),
    .done(lock_done)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mult_ready_bit <= 1'b0;
      mult_enable_bit <= 1'b0;
      mult_init_bit <= 1'b0;
      mult_source_field <= 2'h0;
      mult_run <= 1'b0;
    end
    else
    begin
      mult_ready_bit <= (next_mstate == csm_pkg::CSM_M_LOCKED);
      mult_enable_bit <= cm_en;
      mult_init_bit <= cm_init;
      mult_source_field <= cm_sel;
      // Times-four output gated until locked
      mult_run <= (next_mstate == csm_pkg::CSM_M_LOCKED);
    end
  end

  // Clock select; reserved codes leave the field unchanged
  logic sys_code_ok, usb_code_ok;

  assign sys_code_ok = (wbyte[csm_pkg::CS_SYS_LSB +: 3] <= csm_pkg::SC_LFO)
    && (RATED_48MHZ || (wbyte[csm_pkg::CS_SYS_LSB +: 3] != csm_pkg::SC_MULT));
  assign usb_code_ok = wbyte[csm_pkg::CS_USB_LSB +: 3] <= csm_pkg::UC_EXT_DIV4;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cs_usb <= csm_pkg::RST_CLOCK_SOURCE_SELECT[csm_pkg::CS_USB_LSB +: 3];
      cs_sys <= csm_pkg::RST_CLOCK_SOURCE_SELECT[csm_pkg::CS_SYS_LSB +: 3];
    end
    else if (wr_fire && hit_cs)
    begin
      if (usb_code_ok)
      begin
        cs_usb <= wbyte[csm_pkg::CS_USB_LSB +: 3];
      end
      if (sys_code_ok)
      begin
        cs_sys <= wbyte[csm_pkg::CS_SYS_LSB +: 3];
      end
    end
  end

  // Internal source needs no ready qualification
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sysclk_onehot <= 5'h01;
    end
    else
    begin
      unique case (cs_sys)
        csm_pkg::SC_INT: sysclk_onehot <= 5'h01;
        csm_pkg::SC_EXT: sysclk_onehot <= 5'h02;
        csm_pkg::SC_MULT_DIV2: sysclk_onehot <= 5'h04;
        csm_pkg::SC_MULT: sysclk_onehot <= 5'h08;
        csm_pkg::SC_LFO: sysclk_onehot <= 5'h10;
        default: sysclk_onehot <= 5'h01;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      usb_onehot <= 3'h1;
      usb_ext_div <= 2'h0;
    end
    else
    begin
      usb_onehot <= 3'h4;
      usb_ext_div <= 2'h0;
      unique case (cs_usb)
        csm_pkg::UC_MULT: usb_onehot <= 3'h1;
        csm_pkg::UC_INT_DIV2: usb_onehot <= 3'h2;
        csm_pkg::UC_EXT: usb_ext_div <= 2'h0;
        csm_pkg::UC_EXT_DIV2: usb_ext_div <= 2'h1;
        csm_pkg::UC_EXT_DIV3: usb_ext_div <= 2'h2;
        csm_pkg::UC_EXT_DIV4: usb_ext_div <= 2'h3;
        default: usb_onehot <= 3'h1;
      endcase
    end
  end

endmodule : csm_clock_ctrl

// ### tb/csm_clock_ctrl_checker.sv
module csm_clock_ctrl_checker #(
  parameter int unsigned MULT_LOCK_CYCLES = 4
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic ext_osc_enable, // Osc on
  input wire logic [2:0] ext_osc_mode_field, // Osc mode
  input wire logic ext_osc_div2, // Osc halved
  input wire logic ext_osc_xtal_pins, // Crystal pins
  input wire logic mult_enable_bit, // Mult on
  input wire logic mult_init_bit, // Mult init
  input wire logic mult_ready_bit, // Mult locked
  input wire logic mult_run, // Mult usable
  input wire logic [4:0] sysclk_onehot, // Sys select
  input wire logic [2:0] usb_onehot // USB select
);
  // Margin covers the register hop on each side of the lock timer
  localparam int LOCK_MAX = MULT_LOCK_CYCLES + 6;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  AST_APB_PULSE: assert property (pready |=> !pready) else $error("pready held");
  AST_APB_ERR: assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_XO_ENABLE: assert property (ext_osc_enable == (|ext_osc_mode_field[2:1]))
    else $error("osc enable wrong");
  AST_XO_DIV2: assert property (ext_osc_div2 == (ext_osc_mode_field[1:0] == 2'b11))
    else $error("osc halving wrong");
  AST_XO_PINS: assert property (ext_osc_xtal_pins == (ext_osc_mode_field[2:1] == 2'b11))
    else $error("crystal pins wrong");
  AST_INIT_EN: assert property (mult_init_bit |-> mult_enable_bit)
    else $error("init without enable");
  AST_RDY_RUN: assert property (mult_run == mult_ready_bit) else $error("run differs");
  AST_RDY_LOCK: assert property ($rose(mult_init_bit) |-> ##[1:LOCK_MAX] mult_ready_bit)
    else $error("no lock");
  AST_RDY_CAUSE: assert property ($rose(mult_ready_bit) |-> mult_init_bit && mult_enable_bit)
    else $error("ready uncaused");
  AST_RDY_DROP: assert property ($fell(mult_enable_bit) |-> ##[0:2] !mult_ready_bit)
    else $error("ready stuck");
  AST_SYS_ONEHOT: assert property ($onehot(sysclk_onehot)) else $error("sys select");
  AST_USB_ONEHOT: assert property ($onehot(usb_onehot)) else $error("usb select");
  COV_LOCK: cover property ($rose(mult_ready_bit));
  COV_ERR: cover property (pslverr);
  COV_XTAL: cover property (ext_osc_xtal_pins ##1 !ext_osc_xtal_pins);
endmodule : csm_clock_ctrl_checker

bind csm_clock_ctrl csm_clock_ctrl_checker #(.MULT_LOCK_CYCLES(MULT_LOCK_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .ext_osc_enable(ext_osc_enable), .ext_osc_mode_field(ext_osc_mode_field),
  .ext_osc_div2(ext_osc_div2), .ext_osc_xtal_pins(ext_osc_xtal_pins),
  .mult_enable_bit(mult_enable_bit), .mult_init_bit(mult_init_bit),
  .mult_ready_bit(mult_ready_bit), .mult_run(mult_run), .sysclk_onehot(sysclk_onehot),
  .usb_onehot(usb_onehot));

// ### tb/csm_ext_osc_model.sv
module csm_ext_osc_model #(
  parameter int unsigned SETTLE = 40
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic xtal_on, // Crystal driven
  input wire logic fault, // Amplitude collapse
  output logic amp_ok // Amplitude settled
);
  int unsigned cnt;
  // Slow build-up so a reading right after enabling sees no valid crystal
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 0;
    else if (!xtal_on || fault)
      cnt <= 0;
    else if (cnt < SETTLE)
      cnt <= cnt + 1;
  end
  assign amp_ok = (cnt == SETTLE);
endmodule : csm_ext_osc_model

// ### tb/test_clock_source_select_multiplier.sv
module test_clock_source_select_multiplier;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_CS = {2'b00, csm_pkg::IDX_CLOCK_SOURCE_SELECT, 2'b00};
  localparam logic [11:0] A_XO = {2'b00, csm_pkg::IDX_EXTERNAL_OSC_CONTROL, 2'b00};
  localparam logic [11:0] A_CM = {2'b00, csm_pkg::IDX_CLOCK_MULT_CONTROL, 2'b00};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fault = 0, amp, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, xo_en, xo_d2, xo_pins, m_en, m_init, m_rdy, m_run;
  logic [2:0] xo_mode, xo_freq, usb_oh;
  logic [1:0] m_src, usb_div;
  logic [4:0] sys_oh;
  int fails = 0, cmp_count = 0, cycles = 0;

  csm_clock_ctrl #(.RATED_48MHZ(1'b1), .MULT_LOCK_CYCLES(4), .XTAL_SETTLE_CYCLES(4)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_amp_ok(amp), .ext_osc_enable(xo_en), .ext_osc_mode_field(xo_mode),
    .ext_osc_freq_ctrl(xo_freq), .ext_osc_div2(xo_d2), .ext_osc_xtal_pins(xo_pins),
    .mult_enable_bit(m_en), .mult_init_bit(m_init), .mult_ready_bit(m_rdy),
    .mult_source_field(m_src), .mult_run(m_run), .sysclk_onehot(sys_oh),
    .usb_onehot(usb_oh), .usb_ext_div(usb_div));
  csm_ext_osc_model osc (.pclk(pclk), .presetn(presetn), .xtal_on(xo_pins), .fault(fault),
    .amp_ok(amp));

  always #2 pclk = ~pclk;

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      results();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(name, rd, exp);
  endtask : rdchk

  initial
  begin
    logic [2:0] s;
    int n;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("select", A_CS, 32'h0);
    rdchk("ext ctrl", A_XO, 32'h0);
    rdchk("mult ctrl", A_CM, 32'h0);
    chk("sys out", {27'h0, sys_oh}, 32'h1);
    chk("usb out", {29'h0, usb_oh}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      s = 3'(i % 5);
      apb(1'b1, A_CS, {1'b1, 3'(i), 1'b1, s});
      // Field lands at the pready edge, mux output one edge later
      repeat (2) @(posedge pclk);
      chk("sys out", {27'h0, sys_oh}, 32'h1 << s);
      chk("usb out", {29'h0, usb_oh}, (i < 2) ? (32'h1 << i) : 32'h4);
      if (i >= 2)
        chk("usb div", {30'h0, usb_div}, 32'(i - 2));
      rdchk("select", A_CS, {25'h0, 3'(i), 1'b0, s});
    end
    apb(1'b1, A_CS, 8'hff);
    rdchk("select", A_CS, 32'h50);
    pstrb <= 4'he;
    apb(1'b1, A_CS, 8'h11);
    pstrb <= 4'hf;
    rdchk("select", A_CS, 32'h50);
    $display("test select done");
    for (int m = 0; m < 8; m++)
    begin
      apb(1'b1, A_XO, {1'b0, 3'(m), 1'b1, 3'h7});
      repeat (2) @(posedge pclk);
      chk("osc freq", {29'h0, xo_freq}, 32'h7);
      chk("osc out", {26'h0, xo_en, xo_d2, xo_pins, xo_mode},
        {26'h0, m[2] | m[1], m[1:0] == 2'b11, m[2:1] == 2'b11, 3'(m)});
      rdchk("ext ctrl", A_XO, {25'h0, 3'(m), 4'h7});
    end
    apb(1'b1, A_XO, 8'h67);
    repeat (60) @(posedge pclk);
    rdchk("ext ctrl", A_XO, 32'he7);
    fault <= 1'b1;
    repeat (3) @(posedge pclk);
    rdchk("ext ctrl", A_XO, 32'h67);
    fault <= 1'b0;
    apb(1'b1, A_XO, 8'h47);
    repeat (60) @(posedge pclk);
    rdchk("ext ctrl", A_XO, 32'h47);
    apb(1'b1, A_XO, 8'h67);
    repeat (60) @(posedge pclk);
    $display("test oscillator done");
    apb(1'b1, A_CM, 8'h00);
    apb(1'b1, A_CM, 8'h01);
    apb(1'b1, A_CM, 8'h81);
    repeat (5) @(posedge pclk);
    apb(1'b1, A_CM, 8'hc1);
    n = 0;
    do
    begin
      apb(1'b0, A_CM, 8'h00);
      n++;
    end
    while (rd[5] !== 1'b1 && n < 20);
    chk("mult ctrl", rd, 32'he1);
    chk("mult src", {30'h0, m_src}, 32'h1);
    chk("mult pins", {29'h0, m_en, m_init, m_run}, 32'h7);
    apb(1'b1, A_CM, 8'h00);
    rdchk("mult ctrl", A_CM, 32'h0);
    chk("mult pins", {29'h0, m_en, m_init, m_run}, 32'h0);
    apb(1'b1, A_CM, 8'h42);
    rdchk("mult ctrl", A_CM, 32'h02);
    apb(1'b1, A_CM, 8'h03);
    rdchk("mult ctrl", A_CM, 32'h02);
    apb(1'b1, A_CM, 8'h80);
    repeat (12) @(posedge pclk);
    rdchk("mult ctrl", A_CM, 32'h80);
    $display("test multiplier done");
    apb(1'b0, 12'h000, 8'h00);
    chk("err", {31'h0, er}, 32'h1);
    chk("err data", rd, 32'h0);
    apb(1'b1, 12'h2a8, 8'h5f);
    chk("err", {31'h0, er}, 32'h1);
    rdchk("select", A_CS, 32'h50);
    $display("test unmapped done");
    results();
  end
endmodule : test_clock_source_select_multiplier
